// ==== ibs_pkg.sv ====
// Shared constants, types and register map of the I2C master port
package ibs_pkg;
	// Register indices on the plain register port
	localparam logic [2:0] ADR_RELOAD = 3'h0;
	localparam logic [2:0] ADR_BUF    = 3'h1;
	localparam logic [2:0] ADR_CON1   = 3'h2;
	localparam logic [2:0] ADR_CON2   = 3'h3;
	localparam logic [2:0] ADR_CON3   = 3'h4;
	localparam logic [2:0] ADR_MASK   = 3'h5;
	localparam logic [2:0] ADR_STAT   = 3'h6;
	localparam logic [2:0] ADR_FLAG   = 3'h7;
	localparam logic [7:0] REG_RST    = 8'h00;
	// Status fields
	localparam int B_SMP = 7;
	localparam int B_CKE = 6;
	localparam int B_DA  = 5;
	localparam int B_P   = 4;
	localparam int B_S   = 3;
	localparam int B_RW  = 2;
	localparam int B_UA  = 1;
	localparam int B_BF  = 0;
	// Control one fields
	localparam int B_WCOL = 7;
	localparam int B_OV   = 6;
	localparam int B_EN   = 5;
	localparam int B_CKP  = 4;
	// Control two fields
	localparam int B_GCEN  = 7;
	localparam int B_ACKST = 6;
	localparam int B_ACKDT = 5;
	localparam int B_ACK_REQUEST = 4;
	localparam int B_RECEIVE_REQUEST  = 3;
	localparam int B_PEN   = 2;
	localparam int B_RESTART_REQUEST  = 1;
	localparam int B_SEN   = 0;
	// Event flag register fields
	localparam int B_EVT = 0;
	localparam int B_COL = 1;
	// Port modes
	localparam logic [3:0] MODE_I2C_MST = 4'h8;
	localparam logic [3:0] MODE_SLV10   = 4'h7;
	localparam logic [3:0] MODE_SLV10_I = 4'hF;
	localparam logic [3:0] MODE_SLV7    = 4'h6;
	localparam logic [3:0] MODE_SLV7_I  = 4'hE;
	localparam logic [3:0] MODE_FW_MST  = 4'hB;
	// Clocks per baud counter decrement
	localparam int CY_DIV = 2;
	// Bit counts of the byte engine
	localparam logic [3:0] CNT_TX   = 4'h9;
	localparam logic [3:0] CNT_RX   = 4'h8;
	localparam logic [3:0] CNT_ACK  = 4'h1;
	localparam logic [3:0] CNT_LAST = 4'h1;
	localparam logic [3:0] CNT_ASLT = 4'h2;
	localparam logic [7:0] BRG_ZERO = 8'h00;

	typedef enum logic [1:0] {
		KIND_TX  = 2'b00,
		KIND_RX  = 2'b01,
		KIND_ACK = 2'b10
	} ibs_kind_type;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0000,
		ST_SA   = 4'b0001,
		ST_SB   = 4'b0010,
		ST_RA   = 4'b0011,
		ST_RB   = 4'b0100,
		ST_RC   = 4'b0101,
		ST_RD   = 4'b0110,
		ST_BL   = 4'b0111,
		ST_BW   = 4'b1000,
		ST_BH   = 4'b1001,
		ST_PA   = 4'b1010,
		ST_PB   = 4'b1011,
		ST_PC   = 4'b1100,
		ST_PD   = 4'b1101,
		ST_PE   = 4'b1110
	} ibs_state_type;

	typedef struct packed {
		logic scl;
		logic sda;
	} ibs_pins_type;
endpackage : ibs_pkg

// ==== ibs_master.sv ====
// I2C master port: baud counter, conditions, byte engine and status
`timescale 1ns/1ps
`default_nettype none
module ibs_master
	import ibs_pkg::*;
#(
	parameter int CYC_PER_TICK = CY_DIV
)
(
	// Clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_rst_n,
	// Register port
	input  wire logic [2:0]   i_addr,
	input  wire logic [7:0]   i_wdata,
	input  wire logic         i_wr,
	input  wire logic         i_rd,
	output logic      [7:0]   o_rdata,
	// Bus pins, open drain
	input  wire ibs_pins_type i_pins,
	output ibs_pins_type      o_pin_out,
	output ibs_pins_type      o_pin_oe,
	// Slave address match status
	input  wire logic         i_slave_match,
	input  wire logic         i_slave_rw,
	input  wire logic         i_slave_nack,
	input  wire logic         i_ua_req,
	// Status outputs
	output logic              o_serial_event_flag,
	output logic              o_collision_flag,
	output logic              o_busy,
	output logic              o_slew_ctrl_off,
	output logic              o_smbus_levels,
	output logic              o_spi_sample_end,
	output logic              o_spi_tx_act_idle
);
	if (CYC_PER_TICK < 1 || CYC_PER_TICK > 256)
	begin : g_bad_div
		$error("CYC_PER_TICK must lie in 1..256");
	end

	localparam logic [7:0] CY_LAST = 8'(CYC_PER_TICK - 1);

	function automatic logic is_i2c(input logic [3:0] m);
		return m == MODE_SLV7 || m == MODE_SLV10 || m == MODE_I2C_MST
			|| m == MODE_FW_MST || m == MODE_SLV7_I || m == MODE_SLV10_I;
	endfunction : is_i2c

	function automatic logic hit(input logic s, input logic [2:0] ad,
		input logic [2:0] a);
		return s && ad == a;
	endfunction : hit

	logic [7:0]    reload_q, buf_q, con1_q, con2_q, con3_q, mask_q;
	logic [7:0]    cy_q, brg_q, sh_q, sh_d;
	logic [3:0]    cnt_q, cnt_d;
	ibs_state_type st_q, st_d;
	ibs_kind_type  kind_q, kind_d;
	logic          sda_oe_q, sda_oe_d, scl_oe_q, scl_oe_d;
	logic          smp_q, cke_q, da_q, p_q, s_q, ua_q, bf_q;
	logic          slv_rw_q, txb_q, first_q, evt_q, col_q;
	logic          sda_p_q, scl_p_q;
	logic          cy_en, tmo, brg_ld, fin, col, rx_done, tx_shifted;
	logic          ack_got, first_set, byte_end, active, idle, tx_go;
	logic          start_det, stop_det, slave_mode;
	logic [4:0]    reqs;

	assign active = con1_q[B_EN] && con1_q[3:0] == MODE_I2C_MST;
	assign slave_mode = con1_q[3:0] == MODE_SLV7 || con1_q[3:0] == MODE_SLV10
		|| con1_q[3:0] == MODE_SLV7_I || con1_q[3:0] == MODE_SLV10_I;
	assign reqs = {con2_q[B_ACK_REQUEST], con2_q[B_RECEIVE_REQUEST], con2_q[B_PEN],
		con2_q[B_RESTART_REQUEST], con2_q[B_SEN]};
	assign idle = !txb_q && reqs == 5'h00 && st_q == ST_IDLE;
	assign tx_go = hit(i_wr, i_addr, ADR_BUF) && active && idle;
	assign start_det = scl_p_q && i_pins.scl && sda_p_q && !i_pins.sda;
	assign stop_det = scl_p_q && i_pins.scl && !sda_p_q && i_pins.sda;

	// Divider tick for the baud counter
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n || !active || cy_q == CY_LAST)
			cy_q <= 8'h00;
		else
			cy_q <= cy_q + 8'h01;
	end
	assign cy_en = cy_q == CY_LAST;
	assign tmo = cy_en && brg_q == BRG_ZERO;

	// Baud counter; sits at zero once nothing reloads it
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			brg_q <= BRG_ZERO;
		else if (brg_ld)
			brg_q <= reload_q;
		else if (cy_en && brg_q != BRG_ZERO)
			brg_q <= brg_q - 8'h01;
	end

	always_comb
	begin
		st_d = st_q;
		kind_d = kind_q;
		cnt_d = cnt_q;
		sh_d = sh_q;
		sda_oe_d = sda_oe_q;
		scl_oe_d = scl_oe_q;
		brg_ld = 1'b0;
		fin = 1'b0;
		col = 1'b0;
		rx_done = 1'b0;
		tx_shifted = 1'b0;
		ack_got = 1'b0;
		first_set = 1'b0;
		byte_end = 1'b0;
		case (st_q)
			ST_IDLE:
			begin
				if (tx_go)
				begin
					kind_d = KIND_TX;
					cnt_d = CNT_TX;
					sh_d = i_wdata;
					sda_oe_d = !i_wdata[7];
					brg_ld = 1'b1;
					st_d = ST_BL;
				end
				else if (con2_q[B_SEN])
				begin
					sda_oe_d = 1'b0;
					scl_oe_d = 1'b0;
					brg_ld = 1'b1;
					st_d = ST_SA;
				end
				else if (con2_q[B_RESTART_REQUEST])
				begin
					sda_oe_d = 1'b0;
					brg_ld = 1'b1;
					st_d = ST_RA;
				end
				else if (con2_q[B_PEN])
				begin
					sda_oe_d = 1'b1;
					brg_ld = 1'b1;
					st_d = ST_PA;
				end
				else if (con2_q[B_RECEIVE_REQUEST])
				begin
					kind_d = KIND_RX;
					cnt_d = CNT_RX;
					sda_oe_d = 1'b0;
					brg_ld = 1'b1;
					st_d = ST_BL;
				end
				else if (con2_q[B_ACK_REQUEST])
				begin
					kind_d = KIND_ACK;
					cnt_d = CNT_ACK;
					sda_oe_d = !con2_q[B_ACKDT];
					brg_ld = 1'b1;
					st_d = ST_BL;
				end
			end
			ST_SA:
				if (tmo)
				begin
					sda_oe_d = 1'b1;
					brg_ld = 1'b1;
					st_d = ST_SB;
				end
			ST_SB, ST_RD:
				if (tmo)
				begin
					scl_oe_d = 1'b1;
					fin = 1'b1;
					first_set = 1'b1;
					st_d = ST_IDLE;
				end
			ST_RA:
				if (tmo)
				begin
					scl_oe_d = 1'b0;
					st_d = ST_RB;
				end
			ST_RB:
				if (i_pins.scl)
				begin
					if (!i_pins.sda)
						col = 1'b1;
					brg_ld = 1'b1;
					st_d = ST_RC;
				end
			ST_RC:
				if (!i_pins.scl)
					col = 1'b1;
				else if (tmo)
				begin
					sda_oe_d = 1'b1;
					brg_ld = 1'b1;
					st_d = ST_RD;
				end
			ST_BL:
				if (tmo)
				begin
					scl_oe_d = 1'b0;
					st_d = ST_BW;
				end
			ST_BW:
				// Clock stretching: time the high phase from SCL high
				if (i_pins.scl)
				begin
					brg_ld = 1'b1;
					st_d = ST_BH;
					if (kind_q == KIND_RX)
						sh_d = {sh_q[6:0], i_pins.sda};
					if (kind_q == KIND_TX && cnt_q == CNT_LAST)
						ack_got = 1'b1;
				end
			ST_BH:
				if (kind_q != KIND_RX && !sda_oe_q && !i_pins.sda
					&& !(kind_q == KIND_TX && cnt_q == CNT_LAST))
					col = 1'b1;
				else if (tmo)
				begin
					scl_oe_d = 1'b1;
					cnt_d = cnt_q - 4'h1;
					if (cnt_q == CNT_LAST)
					begin
						fin = 1'b1;
						rx_done = kind_q == KIND_RX;
						byte_end = kind_q != KIND_ACK;
						st_d = ST_IDLE;
					end
					else
					begin
						brg_ld = 1'b1;
						st_d = ST_BL;
						if (kind_q == KIND_TX)
						begin
							sh_d = {sh_q[6:0], 1'b0};
							sda_oe_d = cnt_q != CNT_ASLT && !sh_q[6];
							tx_shifted = cnt_q == CNT_ASLT;
						end
					end
				end
			ST_PA:
				if (i_pins.sda)
					brg_ld = 1'b1;
				else if (tmo)
				begin
					scl_oe_d = 1'b0;
					st_d = ST_PB;
				end
			ST_PB:
				if (i_pins.scl)
				begin
					brg_ld = 1'b1;
					st_d = ST_PC;
				end
			ST_PC:
				if (!i_pins.scl)
					col = 1'b1;
				else if (tmo)
				begin
					sda_oe_d = 1'b0;
					brg_ld = 1'b1;
					st_d = ST_PD;
				end
			ST_PD:
				if (tmo)
				begin
					if (!i_pins.sda)
						col = 1'b1;
					else
					begin
						brg_ld = 1'b1;
						st_d = ST_PE;
					end
				end
			ST_PE:
				if (tmo)
				begin
					fin = 1'b1;
					st_d = ST_IDLE;
				end
			default:
				st_d = ST_IDLE;
		endcase
		if (col || !active)
		begin
			st_d = ST_IDLE;
			sda_oe_d = 1'b0;
			scl_oe_d = 1'b0;
			fin = 1'b0;
			rx_done = 1'b0;
			byte_end = 1'b0;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			st_q <= ST_IDLE;
			kind_q <= KIND_TX;
			cnt_q <= 4'h0;
			sh_q <= REG_RST;
			sda_oe_q <= 1'b0;
			scl_oe_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			kind_q <= kind_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			sda_oe_q <= sda_oe_d;
			scl_oe_q <= scl_oe_d;
		end
	end

	// Plain software registers
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			reload_q <= REG_RST;
			con3_q <= REG_RST;
			mask_q <= REG_RST;
			smp_q <= 1'b0;
			cke_q <= 1'b0;
		end
		else
		begin
			if (hit(i_wr, i_addr, ADR_RELOAD))
				reload_q <= i_wdata;
			if (hit(i_wr, i_addr, ADR_CON3))
				con3_q <= i_wdata;
			if (hit(i_wr, i_addr, ADR_MASK))
				mask_q <= i_wdata;
			if (hit(i_wr, i_addr, ADR_STAT))
			begin
				smp_q <= i_wdata[B_SMP];
				cke_q <= i_wdata[B_CKE];
			end
		end
	end

	// Shift buffer; writes while not idle are dropped and flagged
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			buf_q <= REG_RST;
		else if (rx_done)
			buf_q <= sh_q;
		else if (tx_go)
			buf_q <= i_wdata;
	end

	// Control one: collision and overflow are set by hardware, cleared by 0
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			con1_q <= REG_RST;
		else
		begin
			if (hit(i_wr, i_addr, ADR_CON1))
				con1_q[5:0] <= i_wdata[5:0];
			con1_q[B_WCOL] <= (hit(i_wr, i_addr, ADR_BUF) && !tx_go)
				|| (con1_q[B_WCOL] && !(hit(i_wr, i_addr, ADR_CON1)
				&& !i_wdata[B_WCOL]));
			con1_q[B_OV] <= (rx_done && bf_q)
				|| (con1_q[B_OV] && !(hit(i_wr, i_addr, ADR_CON1)
				&& !i_wdata[B_OV]));
		end
	end

	// Control two: requests only accepted while idle, no queueing
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			con2_q <= REG_RST;
		else
		begin
			if (hit(i_wr, i_addr, ADR_CON2))
			begin
				con2_q[B_GCEN] <= i_wdata[B_GCEN];
				con2_q[B_ACKDT] <= i_wdata[B_ACKDT];
				if (idle && active)
					con2_q[4:0] <= i_wdata[4:0];
			end
			if (fin || col || !active)
				con2_q[4:0] <= 5'h00;
			if (ack_got)
				con2_q[B_ACKST] <= i_pins.sda;
		end
	end

	// Transmit in progress and address/data tracking
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			txb_q <= 1'b0;
			first_q <= 1'b0;
			da_q <= 1'b0;
		end
		else
		begin
			if (tx_go)
				txb_q <= 1'b1;
			else if (fin || col || !active)
				txb_q <= 1'b0;
			if (first_set)
				first_q <= 1'b1;
			else if (byte_end)
			begin
				first_q <= 1'b0;
				da_q <= !first_q;
			end
		end
	end

	// Buffer full: receive or a transmit write fills it, a buffer read empties it when no transmit is in progress
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n || col || !active)
			bf_q <= 1'b0;
		else if (rx_done || tx_go)
			bf_q <= 1'b1;
		else if (tx_shifted || (hit(i_rd, i_addr, ADR_BUF) && !txb_q))
			bf_q <= 1'b0;
	end

	// Bus condition watcher, runs regardless of who drives the bus
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			sda_p_q <= 1'b1;
			scl_p_q <= 1'b1;
			s_q <= 1'b0;
			p_q <= 1'b0;
			slv_rw_q <= 1'b0;
		end
		else
		begin
			sda_p_q <= i_pins.sda;
			scl_p_q <= i_pins.scl;
			if (!con1_q[B_EN])
			begin
				s_q <= 1'b0;
				p_q <= 1'b0;
			end
			else if (start_det)
			begin
				s_q <= 1'b1;
				p_q <= 1'b0;
			end
			else if (stop_det)
			begin
				s_q <= 1'b0;
				p_q <= 1'b1;
			end
			// A match in the same cycle as a condition wins
			if (i_slave_match && slave_mode)
				slv_rw_q <= i_slave_rw;
			else if (start_det || stop_det || i_slave_nack)
				slv_rw_q <= 1'b0;
		end
	end

	// Update-address flag, cleared by a reload register write
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			ua_q <= 1'b0;
		else if (i_ua_req && (con1_q[3:0] == MODE_SLV10
			|| con1_q[3:0] == MODE_SLV10_I))
			ua_q <= 1'b1;
		else if (hit(i_wr, i_addr, ADR_RELOAD))
			ua_q <= 1'b0;
	end

	// Sticky event flags, write one to clear, a new event wins
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			evt_q <= 1'b0;
			col_q <= 1'b0;
		end
		else
		begin
			evt_q <= fin || (evt_q && !(hit(i_wr, i_addr, ADR_FLAG)
				&& i_wdata[B_EVT]));
			col_q <= col || (col_q && !(hit(i_wr, i_addr, ADR_FLAG)
				&& i_wdata[B_COL]));
		end
	end

	// Read data, valid the cycle after the strobe
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			o_rdata <= REG_RST;
		else if (i_rd)
			case (i_addr)
				ADR_RELOAD: o_rdata <= reload_q;
				ADR_BUF:    o_rdata <= buf_q;
				ADR_CON1:   o_rdata <= con1_q;
				ADR_CON2:   o_rdata <= con2_q;
				ADR_CON3:   o_rdata <= con3_q;
				ADR_MASK:   o_rdata <= mask_q;
				ADR_STAT:   o_rdata <= {smp_q, cke_q, da_q, p_q, s_q,
					slave_mode ? slv_rw_q : txb_q, ua_q, bf_q};
				ADR_FLAG:   o_rdata <= {6'h00, col_q, evt_q};
				default:    o_rdata <= REG_RST;
			endcase
		else
			o_rdata <= REG_RST;
	end

	assign o_pin_out = '0;
	assign o_pin_oe = '{scl: scl_oe_q, sda: sda_oe_q};
	assign o_serial_event_flag = evt_q;
	assign o_collision_flag = col_q;
	assign o_busy = txb_q || reqs != 5'h00;
	assign o_slew_ctrl_off = is_i2c(con1_q[3:0]) && smp_q;
	assign o_spi_sample_end = !is_i2c(con1_q[3:0]) && smp_q;
	assign o_smbus_levels = is_i2c(con1_q[3:0]) && cke_q;
	assign o_spi_tx_act_idle = !is_i2c(con1_q[3:0]) && cke_q;
endmodule : ibs_master
`default_nettype wire

// ==== ibs_master_end.sv ====
// Restores the default net type for files read after the design
`default_nettype wire

// ==== ibs_master_props.sv ====
// Checker bound to the I2C master port
`timescale 1ns/1ps
`default_nettype none
module ibs_master_props
	import ibs_pkg::*;
#(
	parameter int CYC_PER_TICK = CY_DIV
)
(
	// Clock and reset
	input wire logic         i_clk,
	input wire logic         i_rst_n,
	// Register port
	input wire logic [2:0]   i_addr,
	input wire logic [7:0]   i_wdata,
	input wire logic         i_wr,
	// Pins and status
	input wire ibs_pins_type i_pins,
	input wire ibs_pins_type o_pin_oe,
	input wire logic         o_busy,
	input wire logic         o_serial_event_flag,
	input wire logic         o_collision_flag,
	input wire logic         o_slew_ctrl_off,
	input wire logic         o_smbus_levels,
	input wire logic         o_spi_sample_end,
	input wire logic         o_spi_tx_act_idle
);
	logic [7:0] reload_q;
	logic       act_q;
	logic       stop_q;
	logic       tx_q;
	int         hi_q;
	int         tbrg;
	logic       go;

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);

	assign tbrg = (int'(reload_q) + 1) * CYC_PER_TICK;
	// Shadows of software requests tell which sequence is running
	assign go = i_wr && !o_busy && act_q;

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			reload_q <= REG_RST;
		else if (i_wr && i_addr == ADR_RELOAD)
			reload_q <= i_wdata;
	end
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			act_q <= 1'b0;
		else if (i_wr && i_addr == ADR_CON1)
			act_q <= i_wdata[B_EN] && i_wdata[3:0] == MODE_I2C_MST;
	end
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n || $fell(o_busy))
		begin
			stop_q <= 1'b0;
			tx_q   <= 1'b0;
		end
		else if (go)
		begin
			stop_q <= stop_q || (i_addr == ADR_CON2 && i_wdata[B_PEN]);
			tx_q   <= tx_q || i_addr == ADR_BUF;
		end
	end
	// Cycles since the clock line was last seen rising
	always_ff @(posedge i_clk)
	begin
		if ($rose(i_pins.scl))
			hi_q <= 1;
		else if (hi_q < 1000)
			hi_q <= hi_q + 1;
	end

	a_buf_starts: assert property (go && i_addr == ADR_BUF
		|-> ##[1:60] $fell(o_pin_oe.scl))
		else $error("buffer write did not start the clock");
	a_req_busy: assert property (go && (i_addr == ADR_BUF
		|| (i_addr == ADR_CON2 && i_wdata[4:0] != 5'h00)) |=> o_busy)
		else $error("accepted request not shown busy");
	a_done_flag: assert property ($fell(o_busy)
		|-> o_serial_event_flag || o_collision_flag)
		else $error("operation ended without a flag");
	a_idle_hold: assert property (!o_busy && !$past(o_busy)
		&& !$past(i_wr) |-> $stable(o_pin_oe))
		else $error("pins moved while idle");
	a_col_release: assert property ($rose(o_collision_flag)
		|-> o_pin_oe == 2'b00 && !o_busy)
		else $error("collision did not release the bus");
	a_stop_order: assert property (stop_q && $fell(o_pin_oe.scl)
		|-> o_pin_oe.sda && !i_pins.sda)
		else $error("clock released before data held low");
	a_stop_sda_col: assert property (stop_q && $fell(o_pin_oe.sda)
		##1 !i_pins.sda [*8] |-> ##[0:4] o_collision_flag)
		else $error("data low after stop release not flagged");
	a_stop_scl_col: assert property (stop_q && o_pin_oe.sda
		&& !o_pin_oe.scl && $fell(i_pins.scl) |-> ##[0:2] o_collision_flag)
		else $error("clock low during stop not flagged");
	a_high_half: assert property (tx_q && $rose(o_pin_oe.scl)
		|-> hi_q >= tbrg - 1 && hi_q <= tbrg + 2)
		else $error("clock high half not one reload period");
	a_smp_map: assert property (i_wr && i_addr == ADR_STAT
		|=> (o_slew_ctrl_off || o_spi_sample_end) == $past(i_wdata[B_SMP])
		&& !(o_slew_ctrl_off && o_spi_sample_end))
		else $error("sample select output wrong");
	a_cke_map: assert property (i_wr && i_addr == ADR_STAT
		|=> (o_smbus_levels || o_spi_tx_act_idle) == $past(i_wdata[B_CKE])
		&& !(o_smbus_levels && o_spi_tx_act_idle))
		else $error("threshold select output wrong");

	c_stop_done: cover property (stop_q && $fell(o_busy) && !o_collision_flag);
	c_collision: cover property ($rose(o_collision_flag));
	c_tx_half: cover property (tx_q && $rose(o_pin_oe.scl));
endmodule : ibs_master_props

bind ibs_master ibs_master_props #(
	.CYC_PER_TICK(CYC_PER_TICK)
) u_props (
	.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_wr(i_wr), .i_pins(i_pins),
	.o_pin_oe(o_pin_oe), .o_busy(o_busy),
	.o_serial_event_flag(o_serial_event_flag),
	.o_collision_flag(o_collision_flag),
	.o_slew_ctrl_off(o_slew_ctrl_off), .o_smbus_levels(o_smbus_levels),
	.o_spi_sample_end(o_spi_sample_end),
	.o_spi_tx_act_idle(o_spi_tx_act_idle)
);
`default_nettype wire

// ==== ibs_bus_model.sv ====
// Other parties on the shared bus: pull-ups, forced lows, clock stretch
`timescale 1ns/1ps
`default_nettype none
module ibs_bus_model
	import ibs_pkg::*;
#(
	parameter int STRETCH = 5
)
(
	// Clock
	input  wire logic         i_clk,
	// Pulls from the port and from the bench
	input  wire ibs_pins_type i_oe,
	input  wire ibs_pins_type i_grab,
	input  wire logic         i_stretch,
	// Resolved line levels
	output ibs_pins_type      o_pins
);
	int rel_q = 0;

	always_ff @(posedge i_clk)
	begin
		if (i_oe.scl)
			rel_q <= 0;
		else if (rel_q < STRETCH)
			rel_q <= rel_q + 1;
	end
	// Pull-ups: a released line floats high; grab is a rival pulling low
	assign o_pins.sda = !(i_oe.sda || i_grab.sda);
	assign o_pins.scl = !(i_oe.scl || i_grab.scl
		|| (i_stretch && rel_q < STRETCH));
endmodule : ibs_bus_model
`default_nettype wire

// ==== ibs_master_tb.sv ====
// Self-checking bench for the I2C master port
`timescale 1ns/1ps
`default_nettype none
module ibs_master_tb
	import ibs_pkg::*;
;
	logic         i_clk = 1'b0;
	logic         i_rst_n = 1'b0;
	logic [2:0]   addr = 3'h0;
	logic [7:0]   wdata = 8'h00;
	logic         wr = 1'b0;
	logic         rd = 1'b0;
	logic [7:0]   rdata;
	ibs_pins_type pins;
	ibs_pins_type oe;
	ibs_pins_type grab = 2'b00;
	logic         stretch = 1'b0;
	logic         busy;
	logic         slew;
	logic         smb;
	logic         smpe;
	logic         txai;
	logic         evt;
	logic         colf;
	logic         smatch = 1'b0;
	logic         srw = 1'b0;
	logic         snack = 1'b0;
	logic         uareq = 1'b0;
	logic [8:0]   sh = 9'h000;
	logic         scl_d = 1'b1;
	int           error_cnt = 0;
	int           checked = 0;

	always #5 i_clk = ~i_clk;

	ibs_master DUT (
		.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
		.i_pins(pins), .o_pin_out(), .o_pin_oe(oe),
		.i_slave_match(smatch), .i_slave_rw(srw),
		.i_slave_nack(snack), .i_ua_req(uareq),
		.o_serial_event_flag(evt), .o_collision_flag(colf),
		.o_busy(busy), .o_slew_ctrl_off(slew),
		.o_smbus_levels(smb), .o_spi_sample_end(smpe),
		.o_spi_tx_act_idle(txai)
	);
	ibs_bus_model u_bus (
		.i_clk(i_clk), .i_oe(oe), .i_grab(grab),
		.i_stretch(stretch), .o_pins(pins)
	);

	// Data line as seen at each clock rise, ack slot last
	always @(posedge i_clk)
	begin
		scl_d <= pins.scl;
		if (pins.scl && !scl_d)
			sh <= {sh[7:0], pins.sda};
	end

	task automatic close_out;
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : close_out

	task automatic chk(input string nm, input logic [7:0] s,
		input logic [7:0] e);
		checked++;
		if (s !== e)
		begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge i_clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge i_clk);
		wr <= 1'b0;
	endtask : wr_reg

	task automatic rd_reg(input logic [2:0] a, input logic [7:0] m,
		input logic [7:0] e, input string nm);
		@(posedge i_clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge i_clk);
		rd <= 1'b0;
		#1;
		chk(nm, rdata & m, e);
	endtask : rd_reg

	task automatic wait_idle;
		int n = 0;
		do
		begin
			@(posedge i_clk);
			#1;
			n++;
		end
		while (busy !== 1'b0 && n < 5000);
		if (n >= 5000)
		begin
			error_cnt++;
			close_out;
		end
		@(posedge i_clk);
	endtask : wait_idle

	task automatic send(input logic [7:0] d, input logic [7:0] da);
		wr_reg(ADR_BUF, d);
		rd_reg(ADR_STAT, 8'h05, 8'h05, "tx busy bits");
		wr_reg(ADR_BUF, 8'h00);
		rd_reg(ADR_CON1, 8'hFF, 8'hA8, "write refused");
		wr_reg(ADR_CON1, 8'h28);
		wait_idle;
		chk("sda bits", sh[8:1], d);
		rd_reg(ADR_STAT, 8'h25, da, "tx done");
		wr_reg(ADR_FLAG, 8'h03);
	endtask : send

	initial
	begin
		repeat (4) @(posedge i_clk);
		i_rst_n <= 1'b1;
		for (int a = 0; a < 8; a++)
			rd_reg(3'(a), 8'hFF, REG_RST, "reset value");
		$display("test reset done");
		wr_reg(ADR_RELOAD, 8'h03);
		wr_reg(ADR_CON1, 8'h28);
		wr_reg(ADR_STAT, 8'hC0);
		rd_reg(ADR_STAT, 8'hC0, 8'hC0, "status selects");
		chk("select ports", {4'h0, slew, smb, smpe, txai}, 8'h0C);
		wr_reg(ADR_STAT, 8'h00);
		$display("test config done");
		wr_reg(ADR_CON2, 8'h01);
		wait_idle;
		rd_reg(ADR_STAT, 8'h18, 8'h08, "start seen");
		rd_reg(ADR_FLAG, 8'h03, 8'h01, "start flag");
		wr_reg(ADR_FLAG, 8'h03);
		send(8'hA5, 8'h00);
		stretch <= 1'b1;
		send(8'h3C, 8'h20);
		stretch <= 1'b0;
		$display("test transmit done");
		wr_reg(ADR_CON2, 8'h08);
		wait_idle;
		rd_reg(ADR_STAT, 8'h01, 8'h01, "rx full");
		rd_reg(ADR_BUF, 8'hFF, 8'hFF, "rx byte");
		rd_reg(ADR_STAT, 8'h01, 8'h00, "rx empty");
		wr_reg(ADR_CON2, 8'h10);
		wait_idle;
		chk("ack sent", {7'h00, sh[0]}, 8'h00);
		rd_reg(ADR_CON2, 8'h10, 8'h00, "ack req clear");
		$display("test receive done");
		wr_reg(ADR_CON2, 8'h04);
		wait_idle;
		rd_reg(ADR_STAT, 8'h18, 8'h10, "stop seen");
		rd_reg(ADR_FLAG, 8'h03, 8'h01, "stop flag");
		chk("flag pins", {6'h00, colf, evt}, 8'h01);
		rd_reg(ADR_CON2, 8'h1F, 8'h00, "requests clear");
		chk("pins idle", {6'h00, oe}, 8'h00);
		$display("test stop done");
		wr_reg(ADR_FLAG, 8'h03);
		wr_reg(ADR_CON2, 8'h01);
		wait_idle;
		grab.sda <= 1'b1;
		wr_reg(ADR_CON2, 8'h04);
		wait_idle;
		grab.sda <= 1'b0;
		rd_reg(ADR_FLAG, 8'h02, 8'h02, "data collision");
		chk("col pin", {7'h00, colf}, 8'h01);
		rd_reg(ADR_CON2, 8'h1F, 8'h00, "stop aborted");
		wr_reg(ADR_FLAG, 8'h03);
		wr_reg(ADR_CON2, 8'h01);
		wait_idle;
		wr_reg(ADR_CON2, 8'h04);
		for (int k = 0; k < 200 && pins.scl !== 1'b1; k++)
			@(posedge i_clk);
		@(posedge i_clk);
		grab.scl <= 1'b1;
		wait_idle;
		grab.scl <= 1'b0;
		rd_reg(ADR_FLAG, 8'h02, 8'h02, "clock collision");
		rd_reg(ADR_STAT, 8'h18, 8'h08, "start kept");
		$display("test collision done");
		wr_reg(ADR_CON1, 8'h08);
		rd_reg(ADR_STAT, 8'h18, 8'h00, "disable clears");
		$display("test disable done");
		wr_reg(ADR_CON1, 8'h27);
		@(posedge i_clk);
		smatch <= 1'b1;
		srw <= 1'b1;
		uareq <= 1'b1;
		@(posedge i_clk);
		smatch <= 1'b0;
		uareq <= 1'b0;
		rd_reg(ADR_STAT, 8'h06, 8'h06, "slave rw ua");
		@(posedge i_clk);
		snack <= 1'b1;
		@(posedge i_clk);
		snack <= 1'b0;
		wr_reg(ADR_RELOAD, 8'h03);
		rd_reg(ADR_STAT, 8'h06, 8'h00, "slave cleared");
		$display("test slave done");
		wr_reg(ADR_CON1, 8'h0A);
		wr_reg(ADR_STAT, 8'hC0);
		@(posedge i_clk);
		chk("spi selects", {4'h0, slew, smb, smpe, txai}, 8'h03);
		$display("test spi done");
		close_out;
	end

	initial
	begin
		repeat (20000) @(posedge i_clk);
		error_cnt++;
		close_out;
	end
endmodule : ibs_master_tb
`default_nettype wire
